// ### src/srb_pkg.sv
/*
 * Shared constants for the stop result register bank: register addresses,
 * field layout, reset values, parity polarity and the sequencing states.
 * Assumes a 6-bit register address supplied by the device's serial host
 * interface logic, which runs on the same reference clock as this bank.
 */
package srb_pkg;

    // Register geometry
    localparam int REG_W     = 24;
    localparam int VAL_W     = 23;
    localparam int PAR_BIT   = 23;
    localparam int COUNT_W   = 16;
    localparam int ADDR_W    = 6;
    localparam int NUM_REGS  = 6;
    localparam int NUM_STOPS = 3;

    // Register addresses, in slot order used by the bank
    localparam logic [5:0] ADDR_STOP2_FINE   = 6'h12;
    localparam logic [5:0] ADDR_STOP2_COARSE = 6'h13;
    localparam logic [5:0] ADDR_STOP3_FINE   = 6'h14;
    localparam logic [5:0] ADDR_STOP3_COARSE = 6'h15;
    localparam logic [5:0] ADDR_STOP4_FINE   = 6'h16;
    localparam logic [5:0] ADDR_STOP4_COARSE = 6'h17;

    // Reset values
    localparam logic [23:0] RESULT_RESET = 24'h000000;
    localparam logic [22:0] VALUE_RESET  = 23'h000000;

    // Parity polarity: 0 gives even parity over all 24 bits
    localparam logic PARITY_ODD = 1'h0;

    // Zero fill above a 16-bit count outside averaging mode
    localparam logic [6:0] COARSE_EXT_ZERO = 7'h00;

    // Measurement sequencing, one-hot
    typedef enum logic [2:0] {
        SRB_IDLE = 3'h1,
        SRB_RUN  = 3'h2,
        SRB_HOLD = 3'h4
    } srb_state_t;

endpackage

// ### src/srb_parity_reg.sv
/*
 * One read-only result register with its parity bit on top.
 * Assumes load and clear come from the bank's sequencer on the same clock;
 * clear takes priority so a fresh measurement never shows stale data.
 */
`timescale 1ns/10ps
module srb_parity_reg (
    input  wire logic                   i_clock,
    input  wire logic                   i_sys_rst,
    input  wire logic                   i_clear,
    input  wire logic                   i_load,
    input  wire logic [srb_pkg::VAL_W-1:0] i_value,
    output logic      [srb_pkg::REG_W-1:0] o_reg
);

    logic [srb_pkg::REG_W-1:0] reg_q;
    logic [srb_pkg::REG_W-1:0] reg_d;

    // Parity is computed once at load and stored with the value
    always_comb begin
        reg_d = reg_q;
        if (i_clear) begin
            reg_d = srb_pkg::RESULT_RESET;
        end else if (i_load) begin
            reg_d = {(^i_value) ^ srb_pkg::PARITY_ODD, i_value};
        end
    end

    // Storage flop; reset overrides any clear or load
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            reg_q <= srb_pkg::RESULT_RESET;
        end else begin
            reg_q <= reg_d;
        end
    end

    assign o_reg = reg_q;

endmodule

// ### src/srb_read_port.sv
/*
 * Read side of the bank: address decode and registered read data.
 * Assumes the serial host interface presents one read strobe per register
 * access on the reference clock; data follows on the next edge.
 */
`timescale 1ns/10ps
module srb_read_port (
    input  wire logic                                        i_clock,
    input  wire logic                                        i_sys_rst,
    input  wire logic                                        i_rd_en,
    input  wire logic [srb_pkg::ADDR_W-1:0]                  i_rd_addr,
    input  wire logic [srb_pkg::NUM_REGS-1:0][srb_pkg::REG_W-1:0] i_regs,
    output logic      [srb_pkg::REG_W-1:0]                   o_rd_data,
    output logic                                             o_rd_valid,
    output logic                                             o_rd_hit
);

    logic [srb_pkg::REG_W-1:0] data_q;
    logic [srb_pkg::REG_W-1:0] data_d;
    logic                      valid_q;
    logic                      valid_d;
    logic                      hit_q;
    logic                      hit_d;

    // Unmapped addresses answer zero with the hit flag low
    always_comb begin
        data_d  = srb_pkg::RESULT_RESET;
        hit_d   = 1'h0;
        valid_d = i_rd_en;
        if (i_rd_en) begin
            unique case (i_rd_addr)
                srb_pkg::ADDR_STOP2_FINE: begin
                    data_d = i_regs[0];
                    hit_d  = 1'h1;
                end
                srb_pkg::ADDR_STOP2_COARSE: begin
                    data_d = i_regs[1];
                    hit_d  = 1'h1;
                end
                srb_pkg::ADDR_STOP3_FINE: begin
                    data_d = i_regs[2];
                    hit_d  = 1'h1;
                end
                srb_pkg::ADDR_STOP3_COARSE: begin
                    data_d = i_regs[3];
                    hit_d  = 1'h1;
                end
                srb_pkg::ADDR_STOP4_FINE: begin
                    data_d = i_regs[4];
                    hit_d  = 1'h1;
                end
                srb_pkg::ADDR_STOP4_COARSE: begin
                    data_d = i_regs[5];
                    hit_d  = 1'h1;
                end
                default: begin
                    data_d = srb_pkg::RESULT_RESET;
                    hit_d  = 1'h0;
                end
            endcase
        end
    end

    // Answer registers: one cycle of latency, data from a flop
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            data_q  <= srb_pkg::RESULT_RESET;
            valid_q <= 1'h0;
            hit_q   <= 1'h0;
        end else begin
            data_q  <= data_d;
            valid_q <= valid_d;
            hit_q   <= hit_d;
        end
    end

    assign o_rd_data  = data_q;
    assign o_rd_valid = valid_q;
    assign o_rd_hit   = hit_q;

endmodule

// ### src/srb_stop_result_bank.sv
/*
 * Stop result register bank: fine time and coarse count results of the
 * second, third and fourth stop events, read-only to the host.
 * Assumes the measurement engine and the serial host interface both run
 * on the reference clock i_clock; their strobes are single-cycle pulses.
 */
`timescale 1ns/10ps
module srb_stop_result_bank (
    input  wire logic                                      i_clock,
    input  wire logic                                      i_sys_rst,
    // Measurement engine side
    input  wire logic                                      i_meas_start,
    input  wire logic                                      i_meas_done,
    input  wire logic                                      i_avg_mode,
    input  wire logic [srb_pkg::NUM_STOPS-1:0]             i_stop_hit,
    input  wire logic [srb_pkg::NUM_STOPS-1:0][srb_pkg::VAL_W-1:0] i_fine,
    input  wire logic [srb_pkg::NUM_STOPS-1:0][srb_pkg::VAL_W-1:0] i_coarse,
    // Host register access, from the serial host interface
    input  wire logic                                      i_rd_en,
    input  wire logic [srb_pkg::ADDR_W-1:0]                i_rd_addr,
    input  wire logic                                      i_wr_en,
    input  wire logic [srb_pkg::ADDR_W-1:0]                i_wr_addr,
    output logic      [srb_pkg::REG_W-1:0]                 o_rd_data,
    output logic                                           o_rd_valid,
    output logic                                           o_rd_hit,
    output logic                                           o_wr_ignored,
    // Status
    output logic                                           o_busy,
    output logic                                           o_results_valid
);

    srb_pkg::srb_state_t state_q;
    srb_pkg::srb_state_t state_d;

    logic                                            clear_all;
    logic                                            load_all;
    logic [srb_pkg::NUM_REGS-1:0]                    load_vec;
    logic [srb_pkg::NUM_REGS-1:0][srb_pkg::VAL_W-1:0] value_vec;
    logic [srb_pkg::NUM_REGS-1:0][srb_pkg::REG_W-1:0] reg_vec;
    logic                                            wr_hit;
    logic                                            wr_ign_q;
    logic                                            wr_ign_d;

    // Sequencer: a start always wins, even in the cycle a done arrives,
    // so a result of an abandoned run can never overwrite a cleared bank
    always_comb begin
        state_d   = state_q;
        clear_all = 1'h0;
        load_all  = 1'h0;
        unique case (state_q)
            srb_pkg::SRB_IDLE: begin
                if (i_meas_start) begin
                    state_d   = srb_pkg::SRB_RUN;
                    clear_all = 1'h1;
                end
            end
            srb_pkg::SRB_RUN: begin
                if (i_meas_start) begin
                    clear_all = 1'h1;
                end else if (i_meas_done) begin
                    state_d  = srb_pkg::SRB_HOLD;
                    load_all = 1'h1;
                end
            end
            srb_pkg::SRB_HOLD: begin
                // Results stand untouched here; a stray done is ignored
                if (i_meas_start) begin
                    state_d   = srb_pkg::SRB_RUN;
                    clear_all = 1'h1;
                end
            end
        endcase
    end

    // State register; reset parks the sequencer in idle
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state_q <= srb_pkg::SRB_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Per stop: fine value as delivered, coarse value zero-extended
    // above 16 bits unless averaging needs the wider accumulation.
    // A stop that never arrived keeps its registers at zero.
    genvar s;
    generate
        for (s = 0; s < srb_pkg::NUM_STOPS; s++) begin : g_stop
            assign value_vec[2*s]   = i_fine[s];
            assign value_vec[2*s+1] = i_avg_mode ? i_coarse[s] :
                {srb_pkg::COARSE_EXT_ZERO, i_coarse[s][srb_pkg::COUNT_W-1:0]};
            assign load_vec[2*s]    = load_all & i_stop_hit[s];
            assign load_vec[2*s+1]  = load_all & i_stop_hit[s];
        end
    endgenerate

    // One storage slice per register; no host write path reaches them
    genvar r;
    generate
        for (r = 0; r < srb_pkg::NUM_REGS; r++) begin : g_reg
            srb_parity_reg u_reg (
                .i_clock   (i_clock),
                .i_sys_rst (i_sys_rst),
                .i_clear   (clear_all),
                .i_load    (load_vec[r]),
                .i_value   (value_vec[r]),
                .o_reg     (reg_vec[r])
            );
        end
    endgenerate

    srb_read_port u_read (
        .i_clock    (i_clock),
        .i_sys_rst  (i_sys_rst),
        .i_rd_en    (i_rd_en),
        .i_rd_addr  (i_rd_addr),
        .i_regs     (reg_vec),
        .o_rd_data  (o_rd_data),
        .o_rd_valid (o_rd_valid),
        .o_rd_hit   (o_rd_hit)
    );

    // Writes into the bank's range are dropped; flag them so the serial
    // interface can tell software its write had no effect
    assign wr_hit = (i_wr_addr >= srb_pkg::ADDR_STOP2_FINE) &&
                    (i_wr_addr <= srb_pkg::ADDR_STOP4_COARSE);

    always_comb begin
        wr_ign_d = i_wr_en & wr_hit;
    end

    // Refusal flag stands for exactly one cycle after the write
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            wr_ign_q <= 1'h0;
        end else begin
            wr_ign_q <= wr_ign_d;
        end
    end

    // Refusal flag from its flop; status decoded straight from the state register
    assign o_wr_ignored    = wr_ign_q;
    assign o_busy          = (state_q == srb_pkg::SRB_RUN);
    assign o_results_valid = (state_q == srb_pkg::SRB_HOLD);

endmodule

// ### test/srb_checker.sv
/*
 * Port assertions for the stop result bank.
 * Assumes one reference clock domain and the bind at the foot of this file.
 */
`timescale 1ns/10ps
module srb_checker (
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    input  wire logic        i_meas_start,
    input  wire logic        i_meas_done,
    input  wire logic        i_rd_en,
    input  wire logic [5:0]  i_rd_addr,
    input  wire logic        i_wr_en,
    input  wire logic [5:0]  i_wr_addr,
    input  wire logic [23:0] o_rd_data,
    input  wire logic        o_rd_valid,
    input  wire logic        o_rd_hit,
    input  wire logic        o_wr_ignored,
    input  wire logic        o_busy,
    input  wire logic        o_results_valid
);
    // Mapped window 12h..17h, decoded here so a shifted decode shows up
    logic rd_in;
    logic wr_in;
    assign rd_in = i_rd_addr inside {[6'h12:6'h17]};
    assign wr_in = i_wr_addr inside {[6'h12:6'h17]};
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    a_read_answers: assert property (i_rd_en |=> o_rd_valid)
        else $error("read strobe not answered");
    a_hit_decode: assert property (i_rd_en |=> o_rd_hit == $past(rd_in))
        else $error("hit flag does not match address");
    a_unmapped_zero: assert property (o_rd_valid && !o_rd_hit |-> o_rd_data == 24'h0)
        else $error("unmapped read not zero");
    a_even_parity: assert property (o_rd_valid |-> !(^o_rd_data))
        else $error("parity of read word is odd");
    a_write_refused: assert property (i_wr_en |=> o_wr_ignored == $past(wr_in))
        else $error("write refusal flag wrong");
    a_reset_clear: assert property ($fell(i_sys_rst) |->
        o_rd_data == 24'h0 && !o_rd_valid && !o_busy && !o_results_valid)
        else $error("outputs not clear after reset");
    a_start_clears: assert property (i_meas_start |=> o_busy && !o_results_valid)
        else $error("start did not enter run");
    a_done_loads: assert property (o_busy && i_meas_done && !i_meas_start
        |=> !o_busy && o_results_valid)
        else $error("done did not enter hold");
    a_hold_kept: assert property (o_results_valid && !i_meas_start |=> o_results_valid)
        else $error("results dropped without start");
    c_hit_read: cover property (i_rd_en && rd_in ##1 o_rd_data != 24'h0);
    c_run_hold: cover property (o_busy ##1 o_results_valid);
    c_write_try: cover property (i_wr_en && wr_in);
endmodule

bind srb_stop_result_bank srb_checker srb_checker_inst (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_meas_start(i_meas_start),
    .i_meas_done(i_meas_done), .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr),
    .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .o_rd_hit(o_rd_hit), .o_wr_ignored(o_wr_ignored),
    .o_busy(o_busy), .o_results_valid(o_results_valid));

// ### test/srb_host_model.sv
/*
 * Host side of the register access: one strobe per read or write.
 * Assumes the bank answers one cycle after the strobe, on the same clock.
 */
`timescale 1ns/10ps
module srb_host_model (
    input  wire logic        i_clock,
    input  wire logic [23:0] i_rd_data,
    input  wire logic        i_rd_valid,
    input  wire logic        i_rd_hit,
    input  wire logic        i_wr_ignored,
    output logic             o_rd_en,
    output logic [5:0]       o_rd_addr,
    output logic             o_wr_en,
    output logic [5:0]       o_wr_addr
);
    // Idle bus: strobes low, addresses not pointing at the bank
    initial begin
        o_rd_en = 1'h0;
        o_rd_addr = 6'h3f;
        o_wr_en = 1'h0;
        o_wr_addr = 6'h3f;
    end
    // Released address goes inverse so a stale value is never trusted
    task automatic read(input logic [5:0] a, output logic [23:0] d, output logic h, v);
        @(negedge i_clock);
        o_rd_en = 1'h1;
        o_rd_addr = a;
        @(negedge i_clock);
        o_rd_en = 1'h0;
        o_rd_addr = ~a;
        d = i_rd_data;
        h = i_rd_hit;
        v = i_rd_valid;
    endtask
    task automatic write(input logic [5:0] a, output logic ign);
        @(negedge i_clock);
        o_wr_en = 1'h1;
        o_wr_addr = a;
        @(negedge i_clock);
        o_wr_en = 1'h0;
        o_wr_addr = ~a;
        ign = i_wr_ignored;
    endtask
endmodule

// ### test/srb_stop_result_bank_bench.sv
/*
 * Self-checking bench for the stop result bank.
 * Assumes the host model drives register access; inputs change at falling edges.
 */
`timescale 1ns/10ps
module srb_stop_result_bank_bench;
    logic             i_clock = 1'h0;
    logic             i_sys_rst = 1'h1;
    logic             start = 1'h0, done = 1'h0, avg = 1'h0;
    logic [2:0]       hit_in = 3'h0;
    logic [2:0][22:0] fine = '0, coarse = '0;
    logic             rd_en, wr_en, rd_valid, rd_hit, wr_ign, busy, res_valid;
    logic [5:0]       rd_addr, wr_addr;
    logic [23:0]      rd_data;
    int               miscompares = 0, samples_checked = 0;
    always #50 i_clock = ~i_clock;
    srb_stop_result_bank srb_stop_result_bank_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_meas_start(start), .i_meas_done(done), .i_avg_mode(avg), .i_stop_hit(hit_in),
        .i_fine(fine), .i_coarse(coarse), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
        .i_wr_en(wr_en), .i_wr_addr(wr_addr), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
        .o_rd_hit(rd_hit), .o_wr_ignored(wr_ign), .o_busy(busy), .o_results_valid(res_valid));
    srb_host_model srb_host_model_inst (.i_clock(i_clock), .i_rd_data(rd_data),
        .i_rd_valid(rd_valid), .i_rd_hit(rd_hit), .i_wr_ignored(wr_ign), .o_rd_en(rd_en),
        .o_rd_addr(rd_addr), .o_wr_en(wr_en), .o_wr_addr(wr_addr));
    task automatic chk_word(input logic [23:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask
    // Expected words built here from the layout, even parity over all 24 bits
    function automatic logic [23:0] coarse_word(input logic [22:0] v, input logic av);
        logic [22:0] b;
        b = {av ? v[22:16] : 7'h0, v[15:0]};
        return {^b, b};
    endfunction
    task automatic rd(input logic [5:0] a, input logic [23:0] exp, input logic hit);
        logic [23:0] d;
        logic        h, v;
        srb_host_model_inst.read(a, d, h, v);
        chk_flag(v, 1'h1);
        chk_flag(h, hit);
        chk_word(d, exp);
    endtask
    // Walk all six slots; a stop not hit must read zero
    task automatic check_all(input logic [2:0] hits, input logic av,
                             input logic [2:0][22:0] f, c);
        for (int i = 0; i < 3; i++) begin
            rd(6'h12 + 6'(2 * i), hits[i] ? {^f[i], f[i]} : 24'h0, 1'h1);
            rd(6'h13 + 6'(2 * i), hits[i] ? coarse_word(c[i], av) : 24'h0, 1'h1);
        end
    endtask
    task automatic measure(input logic [2:0] hits, input logic av);
        @(negedge i_clock);
        start = 1'h1;
        @(negedge i_clock);
        start = 1'h0;
        avg = av;
        hit_in = hits;
        chk_flag(busy, 1'h1);
        @(negedge i_clock);
        done = 1'h1;
        @(negedge i_clock);
        done = 1'h0;
        chk_flag(res_valid, 1'h1);
    endtask
    task automatic t_after_reset();
        check_all(3'h7, 1'h0, '0, '0);
        rd(6'h18, 24'h0, 1'h0);
        rd(6'h11, 24'h0, 1'h0);
        $display("test after_reset done");
    endtask
    task automatic t_results();
        fine = {23'h7fffff, 23'h2aaaaa, 23'h000001};
        coarse = {23'h7fffff, 23'h55ffff, 23'h010001};
        measure(3'h7, 1'h0);
        check_all(3'h7, 1'h0, fine, coarse);
        $display("test results done");
    endtask
    task automatic t_writes();
        logic ign;
        for (logic [5:0] a = 6'h10; a < 6'h1a; a++) begin
            srb_host_model_inst.write(a, ign);
            chk_flag(ign, a inside {[6'h12:6'h17]});
        end
        check_all(3'h7, 1'h0, fine, coarse);
        $display("test writes done");
    endtask
    task automatic t_avg_hold();
        logic [2:0][22:0] f, c;
        fine = {23'h123456, 23'h7e0000, 23'h0abcde};
        coarse = {23'h5a1234, 23'h7fffff, 23'h3f0f0f};
        f = fine;
        c = coarse;
        measure(3'h5, 1'h1);
        check_all(3'h5, 1'h1, f, c);
        fine = '0;
        @(negedge i_clock);
        done = 1'h1;
        @(negedge i_clock);
        done = 1'h0;
        check_all(3'h5, 1'h1, f, c);
        // Reset while results stand, so the wipe is really seen
        i_sys_rst = 1'h1;
        @(negedge i_clock);
        i_sys_rst = 1'h0;
        chk_flag(busy, 1'h0);
        chk_flag(res_valid, 1'h0);
        check_all(3'h0, 1'h0, f, c);
        // Reload, then a fresh start must clear live results
        fine = f;
        measure(3'h5, 1'h1);
        start = 1'h1;
        @(negedge i_clock);
        start = 1'h0;
        chk_flag(busy, 1'h1);
        check_all(3'h0, 1'h0, f, c);
        $display("test avg_hold done");
    endtask
    task automatic wrap_up();
        $display("compares %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog well past the roughly 130 cycles the tests need
    initial begin
        repeat (3000) @(posedge i_clock);
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge i_clock);
        @(negedge i_clock);
        i_sys_rst = 1'h0;
        t_after_reset();
        t_results();
        t_writes();
        t_avg_hold();
        wrap_up();
    end
endmodule
